// file: hdl/mtp_params.svh
// timing, position and encoding constants for the microstep translator
`ifndef MTP_PARAMS_SVH
`define MTP_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define MTP_IDX_W 6
`define MTP_LVL_W 8
`define MTP_CNT_W 12

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MTP_CLK_NS 50
`define MTP_OFF_NS 30000
`define MTP_OFF_CYC (`MTP_OFF_NS / `MTP_CLK_NS)
`define MTP_BLANK_NS 1000
`define MTP_BLANK_CYC (`MTP_BLANK_NS / `MTP_CLK_NS)
`define MTP_FAST_NUM 16'h0005
`define MTP_FAST_SHIFT 4

// ----------------------------------------------------------------
// positions, levels and resolution codes
// ----------------------------------------------------------------
`define MTP_HOME_IDX 6'h08
`define MTP_HOME_LVL 8'hb4
`define MTP_QUARTER 6'h10
`define MTP_RES_FULL 3'h0
`define MTP_RES_HALF 3'h1
`define MTP_RES_QUART 3'h2
`define MTP_RES_EIGHTH 3'h3
`define MTP_RES_SIXT 3'h7
`define MTP_SZ_FULL 6'h10
`define MTP_SZ_HALF 6'h08
`define MTP_SZ_QUART 6'h04
`define MTP_SZ_EIGHTH 6'h02
`define MTP_SZ_SIXT 6'h01
`endif

// file: hdl/mtp_pkg.sv
// shared types of the microstep translator
package mtp_pkg;
`include "mtp_params.svh"

    typedef struct packed {
        logic src_a;
        logic snk_a;
        logic src_b;
        logic snk_b;
    } mtp_bridge_type;

    typedef enum logic [3:0] {
        PW_IDLE = 4'h1,
        PW_ON = 4'h2,
        PW_FAST = 4'h4,
        PW_SLOW = 4'h8
    } mtp_pwm_type;

    typedef struct packed {
        mtp_pwm_type st;
        logic [`MTP_CNT_W-1:0] cnt;
        logic [`MTP_CNT_W-1:0] blank;
        logic zc;
        mtp_bridge_type br;
    } mtp_phase_type;

    typedef struct packed {
        logic step;
        logic dir;
        logic [2:0] res;
        logic run_n;
        logic outs_off;
        logic sleep_n;
        logic overtemp;
        logic lockout;
        logic rail_fault;
        logic pump_low;
        logic trip1;
        logic trip2;
        logic zero1;
        logic zero2;
        logic tie_high;
    } mtp_pins_type;

    typedef struct packed {
        mtp_pins_type s1;
        mtp_pins_type s2;
        mtp_pins_type s3;
        mtp_pins_type filt;
        logic step_q;
        logic [`MTP_IDX_W-1:0] idx;
        logic [`MTP_LVL_W-1:0] lvl1;
        logic [`MTP_LVL_W-1:0] lvl2;
        logic neg1;
        logic neg2;
        logic mix1;
        logic mix2;
        mtp_phase_type ph1;
        mtp_phase_type ph2;
    } mtp_state_type;
endpackage : mtp_pkg

// file: hdl/mtp_translator.sv
// translator, decay selection and fixed off-time chopper of a stepper bridge
`timescale 1ns/1ps
`include "mtp_params.svh"
module mtp_translator
    import mtp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic resolution_sel_0_i,
    input wire logic resolution_sel_1_i,
    input wire logic resolution_sel_2_i,
    input wire logic home_rst_n_i,
    input wire logic outputs_disable_i,
    input wire logic sleep_n_i,
    input wire logic overtemp_i,
    input wire logic supply_lockout_i,
    input wire logic sink_gate_rail_fault_i,
    input wire logic pump_rail_low_i,
    input wire logic sense_trip1_i,
    input wire logic sense_trip2_i,
    input wire logic zero_current1_i,
    input wire logic zero_current2_i,
    input wire logic offtime_resistor_pin_high_i,
    input wire logic [`MTP_CNT_W-1:0] offtime_cycles_i,
    output logic [`MTP_LVL_W-1:0] phase1_level_o,
    output logic [`MTP_LVL_W-1:0] phase2_level_o,
    output logic phase1_neg_o,
    output logic phase2_neg_o,
    output logic phase1_mixed_o,
    output logic phase2_mixed_o,
    output mtp_bridge_type bridge1_o,
    output mtp_bridge_type bridge2_o,
    output logic [`MTP_IDX_W-1:0] position_o
);

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [`MTP_CNT_W-1:0] OFF_CYC = `MTP_CNT_W'(`MTP_OFF_CYC);
    localparam logic [`MTP_CNT_W-1:0] BLANK_CYC = `MTP_CNT_W'(`MTP_BLANK_CYC);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // magnitude of sine at a sixteenth position, 8'hff is full scale
    function automatic logic [`MTP_LVL_W-1:0] sine_mag(input logic [`MTP_IDX_W-1:0] k);
        logic [4:0] m;
        logic [`MTP_LVL_W-1:0] v;
        m = k[4] ? (5'h10 - {1'h0, k[3:0]}) : {1'h0, k[3:0]};
        unique case (m)
            5'h00: v = 8'h00;
            5'h01: v = 8'h19;
            5'h02: v = 8'h32;
            5'h03: v = 8'h4a;
            5'h04: v = 8'h62;
            5'h05: v = 8'h78;
            5'h06: v = 8'h8e;
            5'h07: v = 8'ha2;
            5'h08: v = 8'hb4;
            5'h09: v = 8'hc5;
            5'h0a: v = 8'hd4;
            5'h0b: v = 8'he1;
            5'h0c: v = 8'hec;
            5'h0d: v = 8'hf4;
            5'h0e: v = 8'hfa;
            5'h0f: v = 8'hfe;
            5'h10: v = 8'hff;
            default: v = 8'hff;
        endcase
        return v;
    endfunction : sine_mag

    // sixteenths moved per step for a resolution code
    function automatic logic [`MTP_IDX_W-1:0] step_size(input logic [2:0] res);
        logic [`MTP_IDX_W-1:0] s;
        unique case (res)
            `MTP_RES_HALF: s = `MTP_SZ_HALF;
            `MTP_RES_QUART: s = `MTP_SZ_QUART;
            `MTP_RES_EIGHTH: s = `MTP_SZ_EIGHTH;
            `MTP_RES_SIXT: s = `MTP_SZ_SIXT;
            default: s = `MTP_SZ_FULL; // unused codes act as full step
        endcase
        return s;
    endfunction : step_size

    // next index, snapping to the grid of a coarse resolution first
    function automatic logic [`MTP_IDX_W-1:0] advance(
        input logic [`MTP_IDX_W-1:0] k,
        input logic fwd,
        input logic [2:0] res
    );
        logic [`MTP_IDX_W-1:0] sz;
        logic [`MTP_IDX_W-1:0] org;
        logic [`MTP_IDX_W-1:0] off;
        logic [`MTP_IDX_W-1:0] n;
        sz = step_size(res);
        org = (sz == `MTP_SZ_FULL) ? `MTP_HOME_IDX : '0;
        off = (k - org) & (sz - 6'h01);
        if (off != '0) begin
            n = fwd ? (k + (sz - off)) : (k - off);
        end else begin
            n = fwd ? (k + sz) : (k - sz);
        end
        return n;
    endfunction : advance

    // bridge gates for a chopper state and current polarity
    function automatic mtp_bridge_type gates(
        input mtp_pwm_type st,
        input logic neg,
        input logic zc
    );
        mtp_bridge_type b;
        b = '0;
        unique case (st)
            PW_IDLE: b = '0;
            PW_ON: begin
                b.src_a = !neg;
                b.snk_b = !neg;
                b.src_b = neg;
                b.snk_a = neg;
            end
            PW_FAST: begin
                b.src_a = neg && !zc;
                b.snk_b = neg && !zc;
                b.src_b = !neg && !zc;
                b.snk_a = !neg && !zc;
            end
            PW_SLOW: begin
                b.snk_a = !zc;
                b.snk_b = !zc;
            end
        endcase
        return b;
    endfunction : gates

    // one chopper step of a phase
    function automatic mtp_phase_type pwm_next(
        input mtp_phase_type p,
        input logic neg,
        input logic mixed,
        input logic trip,
        input logic zero,
        input logic run,
        input logic [`MTP_CNT_W-1:0] off_len,
        input logic [`MTP_CNT_W-1:0] tfast
    );
        mtp_phase_type n;
        logic [`MTP_CNT_W:0] cnt1;
        n = p;
        cnt1 = {1'h0, p.cnt} + 13'h0001;
        if (p.blank != '0) begin
            n.blank = p.blank - 12'h001;
        end
        if (!run) begin
            n.st = PW_IDLE;
            n.cnt = '0;
            n.blank = '0;
            n.zc = 1'h0;
        end else begin
            unique case (p.st)
                PW_IDLE: begin
                    n.st = PW_ON;
                    n.blank = BLANK_CYC;
                end
                PW_ON: if (trip && p.blank == '0) begin
                    n.st = (mixed && tfast != '0) ? PW_FAST : PW_SLOW;
                    n.cnt = '0;
                    n.blank = BLANK_CYC;
                    n.zc = 1'h0;
                end
                PW_FAST: begin
                    n.cnt = cnt1[`MTP_CNT_W-1:0];
                    n.zc = p.zc || zero;
                    if (cnt1 >= {1'h0, tfast}) begin
                        n.st = PW_SLOW;
                        n.blank = BLANK_CYC;
                    end
                end
                PW_SLOW: begin
                    n.cnt = cnt1[`MTP_CNT_W-1:0];
                    n.zc = p.zc || zero;
                    if (cnt1 >= {1'h0, off_len}) begin
                        n.st = PW_ON;
                        n.cnt = '0;
                        n.zc = 1'h0;
                        n.blank = BLANK_CYC;
                    end
                end
            endcase
        end
        n.br = gates(n.st, neg, n.zc);
        return n;
    endfunction : pwm_next

    // reset image: home levels, mixed decay, chopper idle
    function automatic mtp_state_type rst_state();
        mtp_state_type s;
        s = '0;
        s.idx = `MTP_HOME_IDX;
        s.lvl1 = `MTP_HOME_LVL;
        s.lvl2 = `MTP_HOME_LVL;
        s.mix1 = 1'h1;
        s.mix2 = 1'h1;
        s.ph1.st = PW_IDLE;
        s.ph2.st = PW_IDLE;
        return s;
    endfunction : rst_state

    localparam mtp_state_type ST_RST = rst_state();

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    mtp_state_type st_r;
    mtp_state_type st_nxt;
    mtp_pins_type pins;
    logic step_edge;
    logic go_home;
    logic outs_ok;
    logic [`MTP_IDX_W-1:0] nidx;
    logic [`MTP_LVL_W-1:0] lvl1_new;
    logic [`MTP_LVL_W-1:0] lvl2_new;
    logic [`MTP_CNT_W-1:0] off_len;
    logic [`MTP_CNT_W-1:0] tfast;
    logic [15:0] fast_prod;

    // pins gathered for the synchroniser
    assign pins = {step_i, dir_i, resolution_sel_2_i, resolution_sel_1_i,
                   resolution_sel_0_i, home_rst_n_i, outputs_disable_i, sleep_n_i,
                   overtemp_i, supply_lockout_i, sink_gate_rail_fault_i,
                   pump_rail_low_i, sense_trip1_i, sense_trip2_i,
                   zero_current1_i, zero_current2_i, offtime_resistor_pin_high_i};

    // translator control terms
    assign step_edge = st_r.filt.step && !st_r.step_q;
    assign go_home = !st_r.filt.run_n || !st_r.filt.sleep_n || st_r.filt.lockout;
    assign outs_ok = !go_home && !st_r.filt.outs_off && !st_r.filt.overtemp
                     && !st_r.filt.rail_fault && !st_r.filt.pump_low;
    assign nidx = go_home ? `MTP_HOME_IDX
                : step_edge ? advance(st_r.idx, st_r.filt.dir, st_r.filt.res)
                : st_r.idx;
    assign lvl1_new = sine_mag(nidx + `MTP_QUARTER);
    assign lvl2_new = sine_mag(nidx);

    // off-time from the timing pin, fast part is 5/16 of it
    assign off_len = st_r.filt.tie_high ? OFF_CYC
                : (offtime_cycles_i == '0) ? 12'h001 : offtime_cycles_i;
    assign fast_prod = {4'h0, off_len} * `MTP_FAST_NUM;
    assign tfast = fast_prod[15:`MTP_FAST_SHIFT];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));
        st_nxt.step_q = st_r.filt.step;
        st_nxt.idx = nidx;
        st_nxt.lvl1 = lvl1_new;
        st_nxt.lvl2 = lvl2_new;
        st_nxt.neg1 = (nidx + `MTP_QUARTER) >= 6'h20;
        st_nxt.neg2 = nidx >= 6'h20;
        if (go_home) begin
            st_nxt.mix1 = 1'h1;
            st_nxt.mix2 = 1'h1;
        end else if (step_edge) begin
            st_nxt.mix1 = lvl1_new < st_r.lvl1;
            st_nxt.mix2 = lvl2_new < st_r.lvl2;
        end
        st_nxt.ph1 = pwm_next(st_r.ph1, st_r.neg1, st_r.mix1, st_r.filt.trip1,
                              st_r.filt.zero1, outs_ok, off_len, tfast);
        st_nxt.ph2 = pwm_next(st_r.ph2, st_r.neg2, st_r.mix2, st_r.filt.trip2,
                              st_r.filt.zero2, outs_ok, off_len, tfast);
    end

    // state register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign phase1_level_o = st_r.lvl1;
    assign phase2_level_o = st_r.lvl2;
    assign phase1_neg_o = st_r.neg1;
    assign phase2_neg_o = st_r.neg2;
    assign phase1_mixed_o = st_r.mix1;
    assign phase2_mixed_o = st_r.mix2;
    assign bridge1_o = st_r.ph1.br;
    assign bridge2_o = st_r.ph2.br;
    assign position_o = st_r.idx;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_home: assert property (
        !st_r.filt.run_n |=> st_r.idx == `MTP_HOME_IDX && st_r.mix1 && st_r.mix2
            && st_r.ph1.br == '0 && st_r.ph2.br == '0)
        else $error("reset did not hold home with outputs off");
    a_sleep_home: assert property (
        !st_r.filt.sleep_n |=> st_r.idx == `MTP_HOME_IDX && st_r.ph1.st == PW_IDLE)
        else $error("sleep did not park the translator");
    a_disable_off: assert property (
        st_r.filt.outs_off |=> st_r.ph1.br == '0 && st_r.ph2.br == '0)
        else $error("bridge driven while disabled");
    a_fault_off: assert property (
        (st_r.filt.overtemp || st_r.filt.rail_fault || st_r.filt.pump_low)
        |=> st_r.ph1.br == '0 && st_r.ph2.br == '0)
        else $error("bridge driven during a fault");
    a_idx_hold: assert property (
        !step_edge && !go_home |=> $stable(st_r.idx) && $stable(st_r.mix1))
        else $error("index moved without a step edge");
    a_step_moves: assert property (
        step_edge && !go_home && st_r.filt.outs_off
        |=> st_r.idx != $past(st_r.idx))
        else $error("step ignored while outputs disabled");
    a_decay_select: assert property (
        step_edge && !go_home
        |=> st_r.mix1 == ($past(lvl1_new) < $past(st_r.lvl1))
            && st_r.mix2 == ($past(lvl2_new) < $past(st_r.lvl2)))
        else $error("wrong decay mode after step");
    a_blank_mask: assert property (
        st_r.ph1.st == PW_ON && st_r.ph1.blank != '0 && outs_ok
        |=> st_r.ph1.st == PW_ON)
        else $error("trip taken inside the mask interval");

    a_trip_mode: assert property (
        st_r.ph1.st == PW_ON && st_r.ph1.blank == '0 && st_r.filt.trip1 && outs_ok
        |=> st_r.ph1.st == (($past(st_r.mix1) && $past(tfast) != '0) ? PW_FAST : PW_SLOW))
        else $error("trip led to the wrong decay");

    a_slow_no_src: assert property (
        st_r.ph2.st == PW_SLOW |-> !st_r.ph2.br.src_a && !st_r.ph2.br.src_b)
        else $error("source on during slow decay");

    a_fast_len: assert property (
        st_r.ph1.st == PW_FAST |-> st_r.ph1.cnt < tfast)
        else $error("fast decay ran past its share");

    a_off_end: assert property (
        st_r.ph1.st == PW_SLOW && ({1'h0, st_r.ph1.cnt} + 13'h0001) >= {1'h0, off_len}
        && outs_ok |=> st_r.ph1.st == PW_ON && st_r.ph1.blank == BLANK_CYC)
        else $error("off-time did not end on time");

    a_zero_recirc: assert property (
        st_r.filt.zero1 && st_r.ph1.st == PW_SLOW && outs_ok
        |=> st_r.ph1.br == '0 || st_r.ph1.st == PW_ON)
        else $error("recirculation kept on at zero current");

    c_step_taken: cover property (step_edge && !go_home && outs_ok);
    c_fast_entered: cover property (st_r.ph1.st == PW_ON ##1 st_r.ph1.st == PW_FAST);
    c_off_done: cover property (st_r.ph2.st == PW_SLOW ##1 st_r.ph2.st == PW_ON);
    c_wake: cover property ($rose(st_r.filt.sleep_n));

endmodule : mtp_translator

// file: testbench/mtp_motion_ctl.sv
// model of the external motion controller driving advance, direction and resolution pins
`timescale 1ns/1ps
module mtp_motion_ctl (
    input wire logic mclk_i,
    input wire logic sleep_n_i,
    output logic step_o,
    output logic dir_o,
    output logic [2:0] sel_o
);
    int unsigned wake_cnt = 30000;

    // ----------------------------------------
    // cycles since the last wake, saturating
    // ----------------------------------------
    always @(posedge mclk_i) begin
        if (!sleep_n_i) begin
            wake_cnt <= 0;
        end else if (wake_cnt < 30000) begin
            wake_cnt <= wake_cnt + 1;
        end
    end

    initial begin
        step_o = 1'b0;
        dir_o = 1'b0;
        sel_o = 3'h7;
    end

    // ----------------------------------------
    // pin tasks, sel order {sel_2, sel_1, sel_0}
    // ----------------------------------------
    task automatic set_pins(input logic d, input logic [2:0] r);
        @(posedge mclk_i);
        #1;
        dir_o = d;
        sel_o = r;
    endtask : set_pins

    task automatic pulse(input logic d, input logic [2:0] r);
        set_pins(d, r);
        while (wake_cnt < 20000) @(posedge mclk_i);
        repeat (4) @(posedge mclk_i);
        #1;
        step_o = 1'b1;
        repeat (20) @(posedge mclk_i);
        #1;
        step_o = 1'b0;
        repeat (20) @(posedge mclk_i);
        #1;
    endtask : pulse
endmodule : mtp_motion_ctl

// file: testbench/microstep_translator_pwm_test.sv
// self-checking bench of the microstep translator and chopper
`timescale 1ns/1ps
`include "mtp_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module microstep_translator_pwm_test import mtp_pkg::*;;
    logic mclk_i, rst_i, home_n, dis, slp_n, ot, uv, rf, pl, tr1, tr2, z1, z2, pinhi;
    logic [`MTP_CNT_W-1:0] off_len;
    logic [`MTP_LVL_W-1:0] lv1, lv2;
    logic [`MTP_IDX_W-1:0] pos;
    logic ng1, ng2, mx1, mx2, step, dir;
    logic [2:0] sel;
    mtp_bridge_type br1, br2;
    int n_errors = 0;
    int n_checks = 0;

    mtp_translator dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .step_i(step), .dir_i(dir),
        .resolution_sel_0_i(sel[0]), .resolution_sel_1_i(sel[1]),
        .resolution_sel_2_i(sel[2]), .home_rst_n_i(home_n), .outputs_disable_i(dis),
        .sleep_n_i(slp_n), .overtemp_i(ot), .supply_lockout_i(uv),
        .sink_gate_rail_fault_i(rf), .pump_rail_low_i(pl), .sense_trip1_i(tr1),
        .sense_trip2_i(tr2), .zero_current1_i(z1), .zero_current2_i(z2),
        .offtime_resistor_pin_high_i(pinhi), .offtime_cycles_i(off_len),
        .phase1_level_o(lv1), .phase2_level_o(lv2), .phase1_neg_o(ng1),
        .phase2_neg_o(ng2), .phase1_mixed_o(mx1), .phase2_mixed_o(mx2),
        .bridge1_o(br1), .bridge2_o(br2), .position_o(pos));

    mtp_motion_ctl ctl_u (.mclk_i(mclk_i), .sleep_n_i(slp_n), .step_o(step), .dir_o(dir),
        .sel_o(sel));

    // ----------------------------------------
    // clock and helpers
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc

    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_mixed;
        logic [3:0] on1;
        cyc(30);
        on1 = br1;
        `CHK(on1 == 4'h9 || on1 == 4'h6, 1'b1)
        tr1 = 1'b1;
        cyc(10);
        tr1 = 1'b0;
        `CHK(br1, ~on1)
        cyc(25);
        `CHK(br1, 4'h5)
        z1 = 1'b1;
        cyc(8);
        `CHK(br1, 4'h0)
        z1 = 1'b0;
        cyc(30);
        tr1 = 1'b1; // trip inside the fresh mask
        cyc(6);
        tr1 = 1'b0;
        cyc(6);
        `CHK(br1, on1)
    endtask : t_mixed

    task automatic t_table;
        logic [2:0] rc [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        logic [5:0] sz [5] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
        for (int i = 0; i < 5; i++) begin
            ctl_u.pulse(1'b1, rc[i]);
            `CHK(pos, 6'h08 + sz[i])
            ctl_u.pulse(1'b0, rc[i]);
            `CHK(pos, 6'h08)
        end
        ctl_u.set_pins(1'b1, 3'h0);
        cyc(40);
        `CHK(pos, 6'h08)
        ctl_u.pulse(1'b1, 3'h7);
        `CHK({mx1, mx2}, 2'b10)
        ctl_u.pulse(1'b1, 3'h0);
        `CHK(pos, 6'h18)
        `CHK({ng1, ng2, lv1, lv2}, {2'b10, 8'hb4, 8'hb4})
        `CHK({mx1, mx2}, 2'b01)
        ctl_u.pulse(1'b0, 3'h0);
        `CHK({mx1, mx2}, 2'b00)
        ctl_u.pulse(1'b1, 3'h1);
        `CHK({lv1, lv2, mx1, mx2}, {8'h00, 8'hff, 2'b10})
        ctl_u.pulse(1'b0, 3'h1);
        ctl_u.pulse(1'b0, 3'h0);
        `CHK(pos, 6'h38)
        ctl_u.pulse(1'b1, 3'h0);
    endtask : t_table

    task automatic t_slow;
        logic [3:0] on2;
        pinhi = 1'b1;
        ctl_u.pulse(1'b1, 3'h7);
        `CHK(mx2, 1'b0)
        on2 = br2;
        tr2 = 1'b1;
        cyc(10);
        tr2 = 1'b0;
        `CHK(br2, 4'h5)
        cyc(560);
        `CHK(br2, 4'h5)
        cyc(50);
        `CHK(br2, on2)
        pinhi = 1'b0;
        ctl_u.pulse(1'b0, 3'h7);
    endtask : t_slow

    task automatic t_gates;
        ctl_u.pulse(1'b1, 3'h2);
        home_n = 1'b0;
        cyc(8);
        `CHK({pos, br1, br2}, {6'h08, 8'h00})
        ctl_u.pulse(1'b1, 3'h2);
        `CHK(pos, 6'h08)
        home_n = 1'b1;
        dis = 1'b1;
        cyc(8);
        `CHK({br1, br2}, 8'h00)
        ctl_u.pulse(1'b1, 3'h7);
        `CHK(pos, 6'h09)
        dis = 1'b0;
        cyc(8);
        `CHK(br1 != 4'h0, 1'b1)
        ctl_u.pulse(1'b0, 3'h7);
        for (int i = 0; i < 4; i++) begin
            ctl_u.pulse(1'b1, 3'h2);
            {ot, uv, rf, pl} = 4'h8 >> i;
            cyc(8);
            `CHK({br1, br2}, 8'h00)
            `CHK(pos == 6'h08, i == 1)
            {ot, uv, rf, pl} = 4'h0;
            cyc(8);
            `CHK(br1 != 4'h0, 1'b1)
            if (i != 1) ctl_u.pulse(1'b0, 3'h2);
        end
        ctl_u.pulse(1'b1, 3'h3);
        slp_n = 1'b0;
        cyc(8);
        `CHK({pos, br1, br2}, {6'h08, 8'h00})
        slp_n = 1'b1;
        cyc(8);
        `CHK(br1 != 4'h0, 1'b1)
        ctl_u.pulse(1'b1, 3'h3);
        `CHK(pos, 6'h0a)
    endtask : t_gates

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {rst_i, home_n, slp_n, dis, ot, uv, rf, pl} = 8'he0;
        {tr1, tr2, z1, z2, pinhi} = 5'h00;
        off_len = 12'h040;
        cyc(16);
        `CHK({br1, br2}, 8'h00)
        rst_i = 1'b0;
        cyc(8);
        `CHK({pos, lv1, lv2}, {6'h08, 8'hb4, 8'hb4})
        `CHK({ng1, ng2, mx1, mx2}, 4'h3)
        t_mixed();
        t_table();
        t_slow();
        t_gates();
        results();
    end

    initial begin
        #3000000;
        n_errors++;
        results();
    end
endmodule : microstep_translator_pwm_test
